// ---- hdl/indirect_data_ram.sv ----
// Data memory reached through the indirect window.
// Assumes one write port and an asynchronous read of the addressed byte.
`timescale 1ns/1ps

module indirect_data_ram #(
  parameter int ADDR_W = 7
) (
  input  wire logic              clk_i,
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic      [7:0]        rdata_o
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] mem [2**ADDR_W];

  // Stores a byte when the window is written.
  always_ff @(posedge clk_i) begin
    if (write_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Presents the addressed byte at once.
  assign rdata_o = mem[addr_i];

endmodule

// ---- hdl/sfr_bank.sv ----
// Upper-bank special register map with mirrored core registers, reached
// over APB (byte address = 4 * index). Assumes rst_i is the power-on reset
// and that the other reset causes arrive as one-cycle synchronous pulses.
`timescale 1ns/1ps

// Function
// - Unimplemented locations and bits read zero; writes to them change nothing.
// - Core registers answer at the same offset in both banks.
// - Counter upper bits only load from the holding latch on counter-low writes.
// - Power-up resets load power-up values, except that brown-out keeps the power-on flag; other resets keep unchanged bits.
// - Master-clear and watchdog resets use the other-reset values.
module sfr_bank
  import sfr_bank_pkg::*;
#(
  parameter int RAM_AW = 7
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        master_clear_pin_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        brownout_reset_i,
  input  wire logic        pc_step_i,
  input  wire logic [5:0]  serial_state_i,
  output logic      [12:0] program_counter_o,
  output logic      [7:0]  core_status_o,
  output logic      [7:0]  timer_option_o,
  output logic      [5:0]  port_a_dir_o,
  output logic      [7:0]  port_b_dir_o,
  output logic      [7:0]  port_c_dir_o,
  output logic      [7:0]  interrupt_control_o,
  output logic      [7:0]  peripheral_irq_enable_o,
  output logic      [7:0]  timer2_period_o,
  output logic      [7:0]  serial_slave_address_o
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [12:0] pc;
  logic [7:0]  core_status;
  logic [7:0]  timer_option;
  logic [7:0]  indirect_pointer;
  logic [5:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_c;
  logic [4:0]  counter_high_latch;
  logic [7:0]  interrupt_control;
  logic [7:0]  pirq_enable;
  logic [1:0]  power_reset_flags;
  logic [7:0]  t2_period;
  logic [7:0]  ser_addr;
  logic [5:0]  ser_state;
  logic [31:0] prdata;
  logic        pready;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire [7:0] idx       = paddr_i[9:2];
  wire       access    = psel_i & penable_i & pready;
  wire       wr        = access & pwrite_i;
  wire       other_rst = master_clear_pin_i | watchdog_reset_i;
  wire       any_rst   = other_rst | brownout_reset_i;

  // Core registers match on the low seven index bits so both banks reach them.
  wire hit_ind  = idx[6:0] == IDX_INDIRECT[6:0];
  wire hit_pcl  = idx[6:0] == IDX_PCL[6:0];
  wire hit_stat = idx[6:0] == IDX_STATUS[6:0];
  wire hit_ptr  = idx[6:0] == IDX_POINTER[6:0];
  wire hit_plat = idx[6:0] == IDX_PCLATCH[6:0];
  wire hit_intc = idx[6:0] == IDX_INTCTRL[6:0];
  // Bank-1-only registers need the full index.
  wire hit_opt  = idx == IDX_OPTION;
  wire hit_dira = idx == IDX_DIR_A;
  wire hit_dirb = idx == IDX_DIR_B;
  wire hit_dirc = idx == IDX_DIR_C;
  wire hit_pie  = idx == IDX_PIRQ_EN;
  wire hit_pwr  = idx == IDX_PWR_FLAGS;
  wire hit_t2p  = idx == IDX_T2_PERIOD;
  wire hit_sadr = idx == IDX_SER_ADDR;
  wire hit_sst  = idx == IDX_SER_STATE;
  wire any_hit  = hit_ind | hit_pcl | hit_stat | hit_ptr | hit_plat | hit_intc | hit_opt
                | hit_dira | hit_dirb | hit_dirc | hit_pie | hit_pwr | hit_t2p
                | hit_sadr | hit_sst;

  // The window pointing at itself reads zero and ignores writes.
  wire       ind_self  = indirect_pointer[6:0] == IDX_INDIRECT[6:0];
  wire       ram_write = wr & hit_ind & ~ind_self;
  wire [7:0] ram_rdata;

  // Read selection; unimplemented bits and locations contribute zero.
  wire [7:0] rd_value =
      ({8{hit_ind & ~ind_self}} & ram_rdata)
    | ({8{hit_opt}}  & timer_option)
    | ({8{hit_pcl}}  & pc[7:0])
    | ({8{hit_stat}} & core_status)
    | ({8{hit_ptr}}  & indirect_pointer)
    | ({8{hit_dira}} & {2'b00, dir_a})
    | ({8{hit_dirb}} & dir_b)
    | ({8{hit_dirc}} & dir_c)
    | ({8{hit_plat}} & {3'b000, counter_high_latch})
    | ({8{hit_intc}} & interrupt_control)
    | ({8{hit_pie}}  & pirq_enable)
    | ({8{hit_pwr}}  & {6'h00, power_reset_flags})
    | ({8{hit_t2p}}  & t2_period)
    | ({8{hit_sadr}} & ser_addr)
    | ({8{hit_sst}}  & {2'b00, ser_state});

  // ==========================================================================
  // APB handshake: one wait state, read data captured with ready
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel_i & penable_i & ~pready;
      prdata <= (psel_i & penable_i & ~pready) ? {24'h00_0000, rd_value} : 32'h0000_0000;
    end
  end

  // Errors are never signalled; unmapped reads return zero instead.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Data memory behind the indirect window
  // ==========================================================================
  indirect_data_ram #(
    .ADDR_W (RAM_AW)
  ) u_ram (
    .clk_i   (clk_i),
    .write_i (ram_write),
    .addr_i  (indirect_pointer[RAM_AW-1:0]),
    .wdata_i (pwdata_i[7:0]),
    .rdata_o (ram_rdata)
  );

  // ==========================================================================
  // Program counter and its high-byte holding latch
  // ==========================================================================
  // A counter-low write loads the whole counter, upper bits from the latch.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= RST_PC;
    end else if (any_rst) begin
      pc <= RST_PC;
    end else if (wr & hit_pcl) begin
      pc <= {counter_high_latch, pwdata_i[7:0]};
    end else if (pc_step_i) begin
      pc <= pc + 13'h0001;
    end
  end

  // The latch is only a buffer; writing it leaves the counter alone.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_high_latch <= RST_PCLATCH;
    end else if (any_rst) begin
      counter_high_latch <= RST_PCLATCH;
    end else if (wr & hit_plat) begin
      counter_high_latch <= pwdata_i[4:0];
    end
  end

  // ==========================================================================
  // Core status: reset cause shows in the timeout and power-down bits
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_status <= RST_STATUS;
    end else if (brownout_reset_i) begin
      core_status <= RST_STATUS;
    end else if (watchdog_reset_i) begin
      core_status <= {3'b000, 1'b0, 1'b1, core_status[2:0]};
    end else if (master_clear_pin_i) begin
      core_status <= {3'b000, core_status[4:0]};
    end else if (wr & hit_stat) begin
      core_status <= (pwdata_i[7:0] & STATUS_SW_MASK) | (core_status & ~STATUS_SW_MASK);
    end
  end

  // ==========================================================================
  // Registers cleared or preset by every reset
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_option <= RST_OPTION;
      dir_a        <= RST_DIR_A;
      dir_b        <= RST_DIR_BC;
      dir_c        <= RST_DIR_BC;
      pirq_enable  <= RST_PIRQ_EN;
      t2_period    <= RST_T2_PERIOD;
      ser_addr     <= RST_SER_ADDR;
    end else if (any_rst) begin
      timer_option <= RST_OPTION;
      dir_a        <= RST_DIR_A;
      dir_b        <= RST_DIR_BC;
      dir_c        <= RST_DIR_BC;
      pirq_enable  <= RST_PIRQ_EN;
      t2_period    <= RST_T2_PERIOD;
      ser_addr     <= RST_SER_ADDR;
    end else if (wr) begin
      timer_option <= hit_opt  ? pwdata_i[7:0] : timer_option;
      dir_a        <= hit_dira ? pwdata_i[5:0] : dir_a;
      dir_b        <= hit_dirb ? pwdata_i[7:0] : dir_b;
      dir_c        <= hit_dirc ? pwdata_i[7:0] : dir_c;
      pirq_enable  <= hit_pie  ? (pwdata_i[7:0] & PIRQ_EN_MASK) : pirq_enable;
      t2_period    <= hit_t2p  ? pwdata_i[7:0] : t2_period;
      ser_addr     <= hit_sadr ? pwdata_i[7:0] : ser_addr;
    end
  end

  // ==========================================================================
  // Registers that keep some or all bits over non-power-up resets
  // ==========================================================================
  // Pointer keeps its value over master-clear and watchdog resets.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indirect_pointer <= RST_POINTER;
    end else if (brownout_reset_i) begin
      indirect_pointer <= RST_POINTER;
    end else if (wr & hit_ptr & ~other_rst) begin
      indirect_pointer <= pwdata_i[7:0];
    end
  end

  // Interrupt control clears bits 7:1; bit 0 is kept by other resets.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_control <= RST_INTCTRL;
    end else if (brownout_reset_i) begin
      interrupt_control <= RST_INTCTRL;
    end else if (other_rst) begin
      interrupt_control <= {RST_INTCTRL[7:1], interrupt_control[0]};
    end else if (wr & hit_intc) begin
      interrupt_control <= pwdata_i[7:0];
    end
  end

  // Power flags: power-on clears both, brown-out clears its own bit,
  // other resets leave both unchanged.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_reset_flags <= RST_PWR_FLAGS;
    end else if (brownout_reset_i) begin
      power_reset_flags[PWR_BOR_BIT] <= 1'b0;
    end else if (wr & hit_pwr & ~other_rst) begin
      power_reset_flags <= pwdata_i[1:0];
    end
  end

  // Serial port state is sampled from the port and read only.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_state <= 6'h00;
    end else begin
      ser_state <= serial_state_i;
    end
  end

  // ==========================================================================
  // Outputs straight from the registers
  // ==========================================================================
  assign prdata_o                = prdata;
  assign pready_o                = pready;
  assign program_counter_o       = pc;
  assign core_status_o           = core_status;
  assign timer_option_o          = timer_option;
  assign port_a_dir_o            = dir_a;
  assign port_b_dir_o            = dir_b;
  assign port_c_dir_o            = dir_c;
  assign interrupt_control_o     = interrupt_control;
  assign peripheral_irq_enable_o = pirq_enable;
  assign timer2_period_o         = t2_period;
  assign serial_slave_address_o  = ser_addr;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ind_write;
    access && pwrite_i && hit_ind && !ind_self && !any_rst;
  endsequence

  sequence s_ptr_held;
    $stable(indirect_pointer);
  endsequence

  AST_UNMAPPED_READ_ZERO: assert property (
    access && !pwrite_i && !any_hit |-> prdata_o == 32'h0000_0000)
    else $error("Unmapped read returned nonzero data.");

  AST_UPPER_BITS_ZERO: assert property (
    access && !pwrite_i && (hit_pwr || hit_plat) |-> prdata_o[31:5] == 27'h0)
    else $error("Unimplemented bits read nonzero.");

  AST_MIRROR_POINTER: assert property (
    access && pwrite_i && idx == (IDX_POINTER & 8'h7F) && !any_rst
      |=> indirect_pointer == $past(pwdata_i[7:0]))
    else $error("Bank-0 pointer write did not reach the pointer.");

  AST_PC_LOAD: assert property (
    access && pwrite_i && hit_pcl && !any_rst
      |=> pc == {$past(counter_high_latch), $past(pwdata_i[7:0])})
    else $error("Counter load did not use the holding latch.");

  AST_LATCH_NO_PC: assert property (
    access && pwrite_i && hit_plat && !any_rst && !pc_step_i |=> $stable(pc))
    else $error("Latch write changed the counter.");

  AST_BROWNOUT_VALUES: assert property (
    brownout_reset_i |=> core_status == RST_STATUS && !power_reset_flags[PWR_BOR_BIT]
      && indirect_pointer == RST_POINTER)
    else $error("Brown-out reset did not load power-up values.");

  AST_CLEAR_KEEPS: assert property (
    master_clear_pin_i && !brownout_reset_i && !watchdog_reset_i
      |=> $stable(indirect_pointer) && core_status[4:0] == $past(core_status[4:0])
      && timer_option == RST_OPTION ##1 pc == RST_PC || pc == 13'h0001)
    else $error("Master-clear reset changed kept bits.");

  AST_WATCHDOG_STATUS: assert property (
    watchdog_reset_i && !brownout_reset_i
      |=> core_status[7:3] == 5'b00001 && $stable(power_reset_flags))
    else $error("Watchdog reset status bits wrong.");

  AST_INDIRECT_RAM: assert property (
    s_ind_write ##1 s_ptr_held |-> ram_rdata == $past(pwdata_i[7:0]))
    else $error("Indirect write did not reach data memory.");

endmodule

// ---- hdl/sfr_bank_pkg.sv ----
// Constants for the upper-bank special register map: register indexes,
// implemented-bit masks and the values taken after each kind of reset.
// Assumes registers sit on APB at byte address = 4 * index.
package sfr_bank_pkg;

  // ==========================================================================
  // Register indexes (bank-1 locations; core registers mirror at index - 80h)
  // ==========================================================================
  localparam logic [7:0] IDX_INDIRECT   = 8'h80;
  localparam logic [7:0] IDX_OPTION     = 8'h81;
  localparam logic [7:0] IDX_PCL        = 8'h82;
  localparam logic [7:0] IDX_STATUS     = 8'h83;
  localparam logic [7:0] IDX_POINTER    = 8'h84;
  localparam logic [7:0] IDX_DIR_A      = 8'h85;
  localparam logic [7:0] IDX_DIR_B      = 8'h86;
  localparam logic [7:0] IDX_DIR_C      = 8'h87;
  localparam logic [7:0] IDX_PCLATCH    = 8'h8A;
  localparam logic [7:0] IDX_INTCTRL    = 8'h8B;
  localparam logic [7:0] IDX_PIRQ_EN    = 8'h8C;
  localparam logic [7:0] IDX_PWR_FLAGS  = 8'h8E;
  localparam logic [7:0] IDX_T2_PERIOD  = 8'h92;
  localparam logic [7:0] IDX_SER_ADDR   = 8'h93;
  localparam logic [7:0] IDX_SER_STATE  = 8'h94;

  // ==========================================================================
  // Field positions and implemented-bit masks
  // ==========================================================================
  localparam int         STATUS_TIMEOUT_BIT   = 4;
  localparam int         STATUS_POWERDOWN_BIT = 3;
  localparam logic [7:0] STATUS_SW_MASK       = 8'hE7; // Timeout and power-down are read-only.
  localparam logic [7:0] PIRQ_EN_MASK         = 8'hCF; // Bits 5:4 are unimplemented.
  localparam int         PWR_POR_BIT          = 1;
  localparam int         PWR_BOR_BIT          = 0;

  // ==========================================================================
  // Values after power-up (power-on, brown-out) and after other resets
  // ==========================================================================
  localparam logic [7:0]  RST_OPTION     = 8'hFF;
  localparam logic [7:0]  RST_STATUS     = 8'h18;
  localparam logic [7:0]  RST_POINTER    = 8'h00;
  localparam logic [5:0]  RST_DIR_A      = 6'h3F;
  localparam logic [7:0]  RST_DIR_BC     = 8'hFF;
  localparam logic [4:0]  RST_PCLATCH    = 5'h00;
  localparam logic [7:0]  RST_INTCTRL    = 8'h00;
  localparam logic [7:0]  RST_PIRQ_EN    = 8'h00;
  localparam logic [1:0]  RST_PWR_FLAGS  = 2'h0;
  localparam logic [7:0]  RST_T2_PERIOD  = 8'hFF;
  localparam logic [7:0]  RST_SER_ADDR   = 8'h00;
  localparam logic [12:0] RST_PC         = 13'h0000;

endpackage

// ---- verif/testbench.sv ----
// Self-checking bench for the upper-bank special register map over APB.
// Assumes sfr_bank_pkg, indirect_data_ram and sfr_bank are compiled first; no other models.
`timescale 1ns/1ps

module testbench;
  import sfr_bank_pkg::*;

  // ==========================================================================
  // Signals, tables and counters
  // ==========================================================================
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pc_step_i;
  logic        master_clear_pin_i, watchdog_reset_i, brownout_reset_i;
  logic [9:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o;
  logic [5:0]  serial_state_i, port_a_dir_o;
  logic [12:0] program_counter_o;
  logic [7:0]  core_status_o, timer_option_o, port_b_dir_o, port_c_dir_o;
  logic [7:0]  interrupt_control_o, peripheral_irq_enable_o;
  logic [7:0]  timer2_period_o, serial_slave_address_o;
  logic [31:0] seed = 32'hFA2F326F;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // Index, power-up value, stored-bit mask and bits software may set.
  localparam logic [103:0] T_IDX = {8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                                    8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h92, 8'h93};
  localparam logic [103:0] T_RST = {8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF,
                                    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  localparam logic [103:0] T_MSK = {8'hFF, 8'hFF, 8'hE7, 8'hFF, 8'h3F, 8'hFF, 8'hFF,
                                    8'h1F, 8'hFF, 8'hCF, 8'h03, 8'hFF, 8'hFF};
  localparam logic [103:0] T_SW  = {8'hFF, 8'hFF, 8'h27, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                    8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF};

  sfr_bank #(.RAM_AW(7)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .master_clear_pin_i(master_clear_pin_i), .watchdog_reset_i(watchdog_reset_i),
    .brownout_reset_i(brownout_reset_i), .pc_step_i(pc_step_i),
    .serial_state_i(serial_state_i), .program_counter_o(program_counter_o),
    .core_status_o(core_status_o), .timer_option_o(timer_option_o),
    .port_a_dir_o(port_a_dir_o), .port_b_dir_o(port_b_dir_o), .port_c_dir_o(port_c_dir_o),
    .interrupt_control_o(interrupt_control_o),
    .peripheral_irq_enable_o(peripheral_irq_enable_o),
    .timer2_period_o(timer2_period_o), .serial_slave_address_o(serial_slave_address_o));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Xorshift source so every run draws the same values.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Output port mirroring a register, with bit 8 set where such a port exists.
  function automatic logic [8:0] port_of(input logic [7:0] idx);
    case (idx)
      8'h81:   return {1'b1, timer_option_o};
      8'h83:   return {1'b1, core_status_o};
      8'h85:   return {3'b100, port_a_dir_o};
      8'h86:   return {1'b1, port_b_dir_o};
      8'h87:   return {1'b1, port_c_dir_o};
      8'h8B:   return {1'b1, interrupt_control_o};
      8'h8C:   return {1'b1, peripheral_irq_enable_o};
      8'h92:   return {1'b1, timer2_period_o};
      8'h93:   return {1'b1, serial_slave_address_o};
      default: return 9'h000;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    logic [31:0] r;
    int          n;
    r = xs();
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {idx, r[1:0]};
    pwdata_i  <= {r[31:8], wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    chk({6'h00, pready_o, pslverr_o, prdata_o[31:8]}, {6'h00, 2'b10, 24'h000000});
    rd = prdata_o[7:0];
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] t;
    apb(1'b1, idx, d, t);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] t;
    apb(1'b0, idx, 8'h00, t);
    chk({24'h0, t}, {24'h0, exp});
  endtask

  task automatic pulse(input int which);
    @(posedge clk_i);
    master_clear_pin_i <= (which == 0);
    watchdog_reset_i   <= (which == 1);
    brownout_reset_i   <= (which == 2);
    @(posedge clk_i);
    {master_clear_pin_i, watchdog_reset_i, brownout_reset_i} <= 3'b000;
  endtask

  task automatic done(input string name);
    $display("test %s done: %0d checks, %0d mismatches", name, n_checks, mismatches);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, reset and hang guard
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [7:0] d, m, p, p2, d2;
    logic [8:0] po;
    logic [12:0] pcs;
    {psel_i, penable_i, pwrite_i, pc_step_i} = 4'h0;
    {master_clear_pin_i, watchdog_reset_i, brownout_reset_i} = 3'b000;
    paddr_i = 10'h000;
    pwdata_i = 32'h00000000;
    serial_state_i = 6'h00;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Power-up values at the registers and at the ports.
    for (int i = 0; i < 13; i++) begin
      rdc(T_IDX[i*8+:8], T_RST[i*8+:8]);
      po = port_of(T_IDX[i*8+:8]);
      if (po[8]) chk({24'h0, po[7:0]}, {24'h0, T_RST[i*8+:8]});
    end
    chk({19'h0, program_counter_o}, {19'h0, RST_PC});
    rdc(8'h80, 8'h00);
    rdc(8'h94, 8'h00);
    done("reset");
    // Random writes; reserved bits are kept as software must.
    for (int i = 0; i < 13; i++) begin
      d = 8'(xs()) & T_SW[i*8+:8];
      if (T_IDX[i*8+:8] == 8'h8E) d = d | 8'h01;
      m = T_MSK[i*8+:8];
      wr(T_IDX[i*8+:8], d);
      rdc(T_IDX[i*8+:8], (d & m) | (T_RST[i*8+:8] & ~m));
      po = port_of(T_IDX[i*8+:8]);
      if (po[8]) chk({24'h0, po[7:0]}, {24'h0, (d & m) | (T_RST[i*8+:8] & ~m)});
      // Core registers reached through the lower bank as well.
      if (T_IDX[i*8+:8] inside {8'h82, 8'h83, 8'h84, 8'h8A, 8'h8B}) begin
        d = 8'(xs()) & T_SW[i*8+:8];
        wr(T_IDX[i*8+:8] ^ 8'h80, d);
        rdc(T_IDX[i*8+:8], (d & m) | (T_RST[i*8+:8] & ~m));
        rdc(T_IDX[i*8+:8] ^ 8'h80, (d & m) | (T_RST[i*8+:8] & ~m));
      end
    end
    done("write");
    // Unmapped locations read zero and ignore writes.
    for (int k = 0; k < 6; k++) begin
      d = 8'({8'h88, 8'h8D, 8'h91, 8'h95, 8'h9F, 8'h05} >> (k * 8));
      wr(d, 8'(xs()));
      rdc(d, 8'h00);
    end
    done("unmapped");
    // Indirect window at two pointer values, through both banks.
    p = 8'(xs()) | 8'h01;
    p2 = p ^ 8'h40;
    d = 8'(xs());
    d2 = 8'(xs());
    wr(8'h84, p);
    wr(8'h80, d);
    wr(8'h04, p2);
    wr(8'h00, d2);
    rdc(8'h84, p2);
    rdc(8'h80, d2);
    wr(8'h84, p);
    rdc(8'h00, d);
    done("indirect");
    // Counter upper bits come from the holding latch on a low-byte write.
    // A latch write must leave the counter where it was.
    pcs = program_counter_o;
    wr(8'h8A, 8'h15);
    #1;
    chk({19'h0, program_counter_o}, {19'h0, pcs});
    wr(8'h82, 8'h34);
    #1;
    chk({19'h0, program_counter_o}, {19'h0, 13'h1534});
    @(posedge clk_i);
    pc_step_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    pc_step_i <= 1'b0;
    #1;
    chk({19'h0, program_counter_o}, {19'h0, 13'h1537});
    @(posedge clk_i);
    serial_state_i <= 6'(xs());
    repeat (2) @(posedge clk_i);
    rdc(8'h94, {2'b00, serial_state_i});
    done("counter");
    // Non-power-up resets keep the unchanged bits; brown-out keeps only the power-on flag.
    wr(8'h83, 8'h27);
    wr(8'h8B, 8'hFF);
    wr(8'h84, 8'h5A);
    wr(8'h8E, 8'h03);
    wr(8'h81, 8'h00);
    pulse(0);
    rdc(8'h83, 8'h1F);
    rdc(8'h8B, 8'h01);
    rdc(8'h84, 8'h5A);
    rdc(8'h8E, 8'h03);
    rdc(8'h81, 8'hFF);
    rdc(8'h8A, 8'h00);
    chk({19'h0, program_counter_o}, {19'h0, RST_PC});
    pulse(1);
    rdc(8'h83, 8'h0F);
    rdc(8'h84, 8'h5A);
    pulse(2);
    rdc(8'h83, RST_STATUS);
    rdc(8'h84, RST_POINTER);
    rdc(8'h8B, RST_INTCTRL);
    rdc(8'h8E, 8'h02);
    done("resets");
    conclude();
  end

endmodule
